// ### logic/ptp_unit_index_status_regs.sv
// Contract
// - Four-bit expected version, resets to two
// - Drop messages with mismatched version
// - Eight-bit domain; capture only matching domain
// - Domain ignored when checking disabled
// - Check enabled: forward match, drop mismatch
// - Window reaches only index-selected units
// - Pin selector routes to pin zero/one
// - Stamp selector routes to unit zero/one
// - Trigger selector 0..2; code 11 reserved
// - Late trigger with notify sets error flag
// - Error clears on one or enable-zero
// - Output event with notify sets done
`timescale 1ns/1ps
`default_nettype none
module ptp_unit_index_status_regs
    import ptp_regs_pkg::*;
(
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            srst,
    // Management register access
    input  wire logic [ptp_regs_pkg::ADDR_W-1:0] regAddr,
    input  wire logic                            regWrite,
    input  wire logic                            regRead,
    input  wire logic [3:0]                      regByteEn,
    input  wire logic [ptp_regs_pkg::DATA_W-1:0] regWdata,
    output logic      [ptp_regs_pkg::DATA_W-1:0] regRdata,
    output logic                                 regRdValid,
    // Indexed window unit strobes
    output logic      [ptp_regs_pkg::NUM_PIN-1:0]   winPinStb,
    output logic      [ptp_regs_pkg::NUM_STAMP-1:0] winStampStb,
    output logic      [ptp_regs_pkg::NUM_TRIG-1:0]  winTrigStb,
    output logic                                 pinSelect,
    output logic                                 stampSelect,
    output logic      [ptp_regs_pkg::TSEL_W-1:0] trigSelect,
    // Trigger unit events
    input  wire logic [ptp_regs_pkg::NUM_TRIG-1:0] trigNotify,
    input  wire logic [ptp_regs_pkg::NUM_TRIG-1:0] trigLate,
    input  wire logic [ptp_regs_pkg::NUM_TRIG-1:0] trigFired,
    input  wire logic [ptp_regs_pkg::NUM_TRIG-1:0] trigEnWrZero,
    output logic                                 trigErrIrq,
    output logic                                 trigDoneIrq,
    // Received message filter
    input  wire logic                            domainCheckEn,
    input  wire logic                            rxValid,
    input  wire logic [ptp_regs_pkg::VER_W-1:0]  rxVersion,
    input  wire logic [ptp_regs_pkg::DOM_W-1:0]  rxDomain,
    output logic                                 rxDecValid,
    output logic                                 rxCapture,
    output logic                                 rxForwardHost,
    output logic                                 rxDrop
);
    import ptp_regs_pkg::*;

    logic [DATA_W-1:0]   domVer_q;
    logic [DATA_W-1:0]   unitIdx_q;
    logic [DATA_W-1:0]   rdata_q;
    logic [DATA_W-1:0]   rdata_d;
    logic                rdValid_q;
    logic [DATA_W-1:0]   byteMask;
    logic                hitDomVer;
    logic                hitIdx;
    logic                hitStatus;
    logic                hitWindow;
    logic                winAccess;
    logic [NUM_TRIG-1:0] errSet;
    logic [NUM_TRIG-1:0] errClr;
    logic [NUM_TRIG-1:0] doneSet;
    logic [NUM_TRIG-1:0] doneClr;
    logic [NUM_TRIG-1:0] errFlags;
    logic [NUM_TRIG-1:0] doneFlags;
    logic [NUM_TRIG-1:0] statClrErr;
    logic [NUM_TRIG-1:0] statClrDone;
    logic [VER_W-1:0]    expVersion;
    logic [DOM_W-1:0]    expDomain;

    // Expand byte enables into a bit mask
    function automatic logic [DATA_W-1:0] lane_mask(input logic [3:0] be);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < 4; i++)
            m[i*8 +: 8] = {8{be[i]}};
        return m;
    endfunction : lane_mask

    // Merge a write into a register honouring lanes and writable bits
    function automatic logic [DATA_W-1:0] merge_wr(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] wdata,
        input logic [DATA_W-1:0] lanes,
        input logic [DATA_W-1:0] wmask
    );
        logic [DATA_W-1:0] upd;
        upd = lanes & wmask;
        return (old & ~upd) | (wdata & upd);
    endfunction : merge_wr

    // One-hot decode of a unit pointer; out-of-range codes select nothing
    function automatic logic [NUM_TRIG-1:0] unit_onehot(input logic [TSEL_W-1:0] sel,
                                                        input int n);
        logic [NUM_TRIG-1:0] oh;
        oh = '0;
        for (int i = 0; i < NUM_TRIG; i++)
            if (i < n && int'(sel) == i)
                oh[i] = 1'b1;
        return oh;
    endfunction : unit_onehot

    assign byteMask  = lane_mask(regByteEn);
    assign hitDomVer = (regAddr[ADDR_W-1:2] == OFS_DOMAIN_VER[ADDR_W-1:2]);
    assign hitIdx    = (regAddr[ADDR_W-1:2] == OFS_UNIT_INDEX[ADDR_W-1:2]);
    assign hitStatus = (regAddr[ADDR_W-1:2] == OFS_TRIG_STATUS[ADDR_W-1:2]);
    assign hitWindow = (regAddr >= OFS_WIN_FIRST) && (regAddr <= OFS_WIN_LAST);
    assign winAccess = hitWindow && (regWrite || regRead);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            domVer_q <= DV_RST;
        else if (regWrite && hitDomVer)
            domVer_q <= merge_wr(domVer_q, regWdata, byteMask, DV_WR_MASK);
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            unitIdx_q <= IDX_RST;
        else if (regWrite && hitIdx)
            unitIdx_q <= merge_wr(unitIdx_q, regWdata, byteMask, IDX_WR_MASK);
    end

    assign expVersion  = domVer_q[VER_LSB +: VER_W];
    assign expDomain   = domVer_q[DOM_LSB +: DOM_W];
    assign pinSelect   = unitIdx_q[PIN_SEL_BIT];
    assign stampSelect = unitIdx_q[STAMP_SEL_BIT];
    assign trigSelect  = unitIdx_q[TSEL_LSB +: TSEL_W];

    // Window strobes: only the selected unit sees the access
    assign winPinStb   = winAccess ? NUM_PIN'(unit_onehot({1'b0, pinSelect}, NUM_PIN))
                                   : '0;
    assign winStampStb = winAccess ? NUM_STAMP'(unit_onehot({1'b0, stampSelect}, NUM_STAMP))
                                   : '0;
    assign winTrigStb  = winAccess ? unit_onehot(trigSelect, NUM_TRIG) : '0;

    // Status flag events and clears
    assign errSet      = trigNotify & trigLate;
    assign doneSet     = trigNotify & trigFired;
    assign statClrErr  = (regWrite && hitStatus)
                         ? (regWdata[TERR_LSB +: NUM_TRIG] & byteMask[TERR_LSB +: NUM_TRIG])
                         : '0;
    assign statClrDone = (regWrite && hitStatus)
                         ? (regWdata[TDONE_LSB +: NUM_TRIG] & byteMask[TDONE_LSB +: NUM_TRIG])
                         : '0;
    assign errClr      = statClrErr | trigEnWrZero;
    assign doneClr     = statClrDone;

    w1c_flags #(
        .W (NUM_TRIG)
    ) u_err_flags (
        .sys_clk (sys_clk),
        .srst    (srst),
        .setEv   (errSet),
        .clrEv   (errClr),
        .flags   (errFlags)
    );

    w1c_flags #(
        .W (NUM_TRIG)
    ) u_done_flags (
        .sys_clk (sys_clk),
        .srst    (srst),
        .setEv   (doneSet),
        .clrEv   (doneClr),
        .flags   (doneFlags)
    );

    assign trigErrIrq  = |errFlags;
    assign trigDoneIrq = |doneFlags;

    // Read mux; bits outside the write masks and unmapped addresses read zero
    always_comb
    begin
        rdata_d = '0;
        if (hitDomVer)
            rdata_d = domVer_q & DV_WR_MASK;
        else if (hitIdx)
            rdata_d = unitIdx_q & IDX_WR_MASK;
        else if (hitStatus)
        begin
            rdata_d[TERR_LSB +: NUM_TRIG]  = errFlags;
            rdata_d[TDONE_LSB +: NUM_TRIG] = doneFlags;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            rdata_q <= '0;
        else if (regRead)
            rdata_q <= rdata_d;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            rdValid_q <= 1'b0;
        else
            rdValid_q <= regRead && !hitWindow;
    end

    assign regRdata   = rdata_q;
    assign regRdValid = rdValid_q;

    rx_msg_filter u_rx_filter (
        .sys_clk       (sys_clk),
        .srst          (srst),
        .expVersion    (expVersion),
        .expDomain     (expDomain),
        .domainCheckEn (domainCheckEn),
        .rxValid       (rxValid),
        .rxVersion     (rxVersion),
        .rxDomain      (rxDomain),
        .rxDecValid    (rxDecValid),
        .rxCapture     (rxCapture),
        .rxForwardHost (rxForwardHost),
        .rxDrop        (rxDrop)
    );

    sequence seqVerWrite;
        regWrite && hitDomVer && regByteEn[1];
    endsequence

    sequence seqStatusRead;
        regRead && hitStatus ##1 1'b1;
    endsequence

    sequence seqDomWrite;
        regWrite && hitDomVer && byteMask[DOM_LSB];
    endsequence

    AST_VER_WRITE: assert property (@(posedge sys_clk) disable iff (srst)
        seqVerWrite |=> expVersion == $past(regWdata[VER_LSB +: VER_W]))
        else $error("version write not stored");
    AST_WIN_TRIG: assert property (@(posedge sys_clk) disable iff (srst)
        winTrigStb != '0 |-> hitWindow && winTrigStb == (3'h1 << trigSelect))
        else $error("window strobe to wrong trigger unit");
    AST_PIN_SEL: assert property (@(posedge sys_clk) disable iff (srst)
        winAccess |-> winPinStb[1] == pinSelect && winPinStb[0] == !pinSelect)
        else $error("pin strobe mismatch");
    AST_STAMP_SEL: assert property (@(posedge sys_clk) disable iff (srst)
        winAccess |-> winStampStb[1] == stampSelect && winStampStb[0] == !stampSelect)
        else $error("stamp strobe mismatch");
    AST_TRIG_RSVD: assert property (@(posedge sys_clk) disable iff (srst)
        trigSelect == TSEL_RESERVED |-> winTrigStb == '0)
        else $error("reserved trigger code selected a unit");
    AST_ERR_SET: assert property (@(posedge sys_clk) disable iff (srst)
        errSet != '0 |=> ((errFlags & $past(errSet)) == $past(errSet)) && trigErrIrq)
        else $error("late trigger did not set error");
    AST_ERR_CLR: assert property (@(posedge sys_clk) disable iff (srst)
        trigEnWrZero[0] && !errSet[0] |=> !errFlags[0])
        else $error("enable-zero did not clear error");
    AST_DONE_SET: assert property (@(posedge sys_clk) disable iff (srst)
        doneSet[0] |=> doneFlags[0] && trigDoneIrq)
        else $error("done flag not set");
    AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
        seqStatusRead |-> regRdValid && regRdata[DATA_W-1:TERR_LSB+NUM_TRIG] == '0)
        else $error("reserved status bits nonzero");
    AST_RST_VALUES: assert property (@(posedge sys_clk) disable iff (srst)
        $past(srst) |-> expVersion == DV_RST[VER_LSB +: VER_W]
                        && expDomain == DV_RST[DOM_LSB +: DOM_W])
        else $error("version or domain not at reset value");
    AST_RST_INDEX: assert property (@(posedge sys_clk) disable iff (srst)
        $past(srst) |-> !pinSelect && !stampSelect && trigSelect == '0)
        else $error("index fields not at reset value");
    AST_RST_FLAGS: assert property (@(posedge sys_clk) disable iff (srst)
        $past(srst) |-> errFlags == '0 && doneFlags == '0 && !regRdValid)
        else $error("status not clear after reset");
    AST_DOM_WRITE: assert property (@(posedge sys_clk) disable iff (srst)
        seqDomWrite |=> expDomain == $past(regWdata[DOM_LSB +: DOM_W]))
        else $error("domain write not stored");
    AST_IDX_WRITE: assert property (@(posedge sys_clk) disable iff (srst)
        regWrite && hitIdx && (&regByteEn)
        |=> trigSelect == $past(regWdata[TSEL_LSB +: TSEL_W])
            && pinSelect == $past(regWdata[PIN_SEL_BIT])
            && stampSelect == $past(regWdata[STAMP_SEL_BIT]))
        else $error("index write not stored");
    AST_ERR_W1C: assert property (@(posedge sys_clk) disable iff (srst)
        regWrite && hitStatus && byteMask[TERR_LSB] && regWdata[TERR_LSB] && !errSet[0]
        |=> !errFlags[0])
        else $error("error flag not cleared by one");
    AST_DONE_W1C: assert property (@(posedge sys_clk) disable iff (srst)
        regWrite && hitStatus && byteMask[TDONE_LSB] && regWdata[TDONE_LSB] && !doneSet[0]
        |=> !doneFlags[0])
        else $error("done flag not cleared by one");
    AST_ZERO_KEEP: assert property (@(posedge sys_clk) disable iff (srst)
        regWrite && hitStatus && regWdata == '0 && errSet == '0 && doneSet == '0
        && trigEnWrZero == '0 |=> errFlags == $past(errFlags) && doneFlags == $past(doneFlags))
        else $error("zero write changed a status flag");
    AST_RD_ANSWER: assert property (@(posedge sys_clk) disable iff (srst)
        regRead && !hitWindow |=> regRdValid)
        else $error("register read not answered");
    AST_RD_WINDOW: assert property (@(posedge sys_clk) disable iff (srst)
        regRead && hitWindow |=> !regRdValid)
        else $error("window read answered locally");
    AST_NO_WIN: assert property (@(posedge sys_clk) disable iff (srst)
        !winAccess |-> winPinStb == '0 && winStampStb == '0 && winTrigStb == '0)
        else $error("unit strobe outside window access");
    AST_ERR_CAUSE: assert property (@(posedge sys_clk) disable iff (srst)
        !errSet[0] && !errFlags[0] |=> !errFlags[0])
        else $error("error flag set without late trigger");
endmodule : ptp_unit_index_status_regs
`default_nettype wire

// ### common/ptp_regs_pkg.sv
`default_nettype none
package ptp_regs_pkg;
    localparam int          ADDR_W           = 16;
    localparam int          DATA_W           = 32;
    localparam int          NUM_TRIG         = 3;
    localparam int          NUM_STAMP        = 2;
    localparam int          NUM_PIN          = 2;
    localparam int          VER_W            = 4;
    localparam int          DOM_W            = 8;
    localparam int          TSEL_W           = 2;
    // Register byte addresses
    localparam logic [15:0] OFS_DOMAIN_VER   = 16'h0518;
    localparam logic [15:0] OFS_UNIT_INDEX   = 16'h0520;
    localparam logic [15:0] OFS_TRIG_STATUS  = 16'h0524;
    localparam logic [15:0] OFS_WIN_FIRST    = 16'h052C;
    localparam logic [15:0] OFS_WIN_LAST     = 16'h05B3;
    // Field positions
    localparam int          VER_LSB          = 8;
    localparam int          DOM_LSB          = 0;
    localparam int          PIN_SEL_BIT      = 16;
    localparam int          STAMP_SEL_BIT    = 8;
    localparam int          TSEL_LSB         = 0;
    localparam int          TERR_LSB         = 16;
    localparam int          TDONE_LSB        = 0;
    // Writable bits (reserved R/W bits included) and reset values
    localparam logic [31:0] DV_WR_MASK       = 32'h00000FFF;
    localparam logic [31:0] IDX_WR_MASK      = 32'h000F0F03;
    localparam logic [31:0] DV_RST           = 32'h00000200;
    localparam logic [31:0] IDX_RST          = 32'h00000000;
    localparam logic [1:0]  TSEL_RESERVED    = 2'h3;
endpackage : ptp_regs_pkg
`default_nettype wire

// ### logic/w1c_flags.sv
`timescale 1ns/1ps
`default_nettype none
module w1c_flags #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         srst,
    // Events and clears
    input  wire logic [W-1:0] setEv,
    input  wire logic [W-1:0] clrEv,
    // Flags
    output logic      [W-1:0] flags
);
    logic [W-1:0] flags_q;
    logic [W-1:0] flags_d;

    // Set wins over a clear in the same cycle
    assign flags_d = (flags_q & ~clrEv) | setEv;
    assign flags   = flags_q;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            flags_q <= '0;
        else
            flags_q <= flags_d;
    end

    AST_W1C_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
        (setEv == '0 && clrEv == '0) |=> $stable(flags_q))
        else $error("flag changed without set or clear");
endmodule : w1c_flags
`default_nettype wire

// ### logic/rx_msg_filter.sv
`timescale 1ns/1ps
`default_nettype none
module rx_msg_filter
    import ptp_regs_pkg::*;
(
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       srst,
    // Programmed values
    input  wire logic [ptp_regs_pkg::VER_W-1:0] expVersion,
    input  wire logic [ptp_regs_pkg::DOM_W-1:0] expDomain,
    input  wire logic                       domainCheckEn,
    // Received message header
    input  wire logic                       rxValid,
    input  wire logic [ptp_regs_pkg::VER_W-1:0] rxVersion,
    input  wire logic [ptp_regs_pkg::DOM_W-1:0] rxDomain,
    // Decision
    output logic                            rxDecValid,
    output logic                            rxCapture,
    output logic                            rxForwardHost,
    output logic                            rxDrop
);
    import ptp_regs_pkg::*;

    logic verOk;
    logic domOk;
    logic keep;
    logic decValid_q;
    logic keep_q;

    assign verOk = (rxVersion == expVersion);
    assign domOk = !domainCheckEn || (rxDomain == expDomain);
    assign keep  = verOk && domOk;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            decValid_q <= 1'b0;
        else
            decValid_q <= rxValid;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            keep_q <= 1'b0;
        else if (rxValid)
            keep_q <= keep;
    end

    assign rxDecValid    = decValid_q;
    assign rxCapture     = decValid_q && keep_q;
    assign rxForwardHost = decValid_q && keep_q;
    assign rxDrop        = decValid_q && !keep_q;

    sequence seqRxVerMiss;
        rxValid && (rxVersion != expVersion);
    endsequence

    AST_VER_DROP: assert property (@(posedge sys_clk) disable iff (srst)
        seqRxVerMiss |=> rxDecValid && rxDrop && !rxCapture)
        else $error("version mismatch not dropped");
    AST_DOM_MATCH: assert property (@(posedge sys_clk) disable iff (srst)
        rxValid && domainCheckEn && verOk && (rxDomain == expDomain) |=> rxCapture)
        else $error("matching domain not captured");
    AST_DOM_IGNORE: assert property (@(posedge sys_clk) disable iff (srst)
        rxValid && !domainCheckEn && verOk |=> rxCapture && rxForwardHost)
        else $error("domain used while check off");
    AST_DOM_DROP: assert property (@(posedge sys_clk) disable iff (srst)
        rxValid && domainCheckEn && (rxDomain != expDomain) |=> rxDrop && !rxForwardHost)
        else $error("foreign domain forwarded");
endmodule : rx_msg_filter
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("ERROR %0t got %h expected %h", $time, got, exp); \
        end \
    end
module tb_top;
    import ptp_regs_pkg::*;
    typedef struct packed {logic [15:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;} regRow_t;
    typedef struct packed {logic chk; logic [3:0] v; logic [7:0] dm; logic [2:0] e;} rxRow_t;
    // Design ports
    logic                 sys_clk;
    logic                 srst;
    logic [ADDR_W-1:0]    regAddr;
    logic                 regWrite;
    logic                 regRead;
    logic [3:0]           regByteEn;
    logic [DATA_W-1:0]    regWdata;
    logic [DATA_W-1:0]    regRdata;
    logic                 regRdValid;
    logic [NUM_PIN-1:0]   winPinStb;
    logic [NUM_STAMP-1:0] winStampStb;
    logic [NUM_TRIG-1:0]  winTrigStb;
    logic                 pinSelect;
    logic                 stampSelect;
    logic [TSEL_W-1:0]    trigSelect;
    logic [NUM_TRIG-1:0]  trigNotify;
    logic [NUM_TRIG-1:0]  trigLate;
    logic [NUM_TRIG-1:0]  trigFired;
    logic [NUM_TRIG-1:0]  trigEnWrZero;
    logic                 trigErrIrq;
    logic                 trigDoneIrq;
    logic                 domainCheckEn;
    logic                 rxValid;
    logic [VER_W-1:0]     rxVersion;
    logic [DOM_W-1:0]     rxDomain;
    logic                 rxDecValid;
    logic                 rxCapture;
    logic                 rxForwardHost;
    logic                 rxDrop;
    // Bench state
    int                   err_total;
    int                   cmp_count;
    logic [DATA_W-1:0]    rdVal;
    regRow_t              regRows [8] = '{
        '{16'h0518, 4'hF, 32'hFFFFFFFF, 32'h00000FFF},
        '{16'h0518, 4'h1, 32'h00000A55, 32'h00000F55},
        '{16'h0518, 4'h2, 32'h00000300, 32'h00000355},
        '{16'h0520, 4'hF, 32'hFFFFFFFE, 32'h000F0F02},
        '{16'h0520, 4'hF, 32'h00000000, 32'h00000000},
        '{16'h0524, 4'hF, 32'hFFFFFFFF, 32'h00000000},
        '{16'h0528, 4'hF, 32'hFFFFFFFF, 32'h00000000},
        '{16'h0518, 4'h3, 32'h00000212, 32'h00000212}};
    rxRow_t               rxRows [7] = '{
        '{1'h0, 4'h2, 8'h12, 3'h6}, '{1'h0, 4'h2, 8'h34, 3'h6}, '{1'h1, 4'h2, 8'h12, 3'h6},
        '{1'h1, 4'h2, 8'h34, 3'h1}, '{1'h0, 4'h3, 8'h12, 3'h1}, '{1'h1, 4'h1, 8'h12, 3'h1},
        '{1'h0, 4'hF, 8'h00, 3'h1}};

    ptp_unit_index_status_regs ptp_unit_index_status_regs_inst (
        .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regByteEn(regByteEn), .regWdata(regWdata), .regRdata(regRdata),
        .regRdValid(regRdValid), .winPinStb(winPinStb), .winStampStb(winStampStb),
        .winTrigStb(winTrigStb), .pinSelect(pinSelect), .stampSelect(stampSelect),
        .trigSelect(trigSelect), .trigNotify(trigNotify), .trigLate(trigLate),
        .trigFired(trigFired), .trigEnWrZero(trigEnWrZero), .trigErrIrq(trigErrIrq),
        .trigDoneIrq(trigDoneIrq), .domainCheckEn(domainCheckEn), .rxValid(rxValid),
        .rxVersion(rxVersion), .rxDomain(rxDomain), .rxDecValid(rxDecValid),
        .rxCapture(rxCapture), .rxForwardHost(rxForwardHost), .rxDrop(rxDrop));

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic regWr(input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regByteEn = be;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge sys_clk);
        regWrite = 1'b0;
    endtask : regWr

    task automatic regRd(input logic [15:0] a, output logic [31:0] d);
        int i;
        @(negedge sys_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge sys_clk);
        regRead = 1'b0;
        for (i = 0; i < 4 && regRdValid !== 1'b1; i++)
            @(negedge sys_clk);
        if (regRdValid !== 1'b1)
        begin
            err_total++;
            $display("ERROR %0t read answer missing", $time);
            final_report();
        end
        d = regRdata;
    endtask : regRd

    // Index write, then a read strobe at the given address and its unit strobes
    task automatic winChk(input logic [31:0] idx, input logic [15:0] a, input logic [6:0] e,
                          input logic vld);
        regWr(OFS_UNIT_INDEX, 4'hF, idx);
        `CHK({pinSelect, stampSelect, trigSelect}, {idx[16], idx[8], idx[1:0]})
        @(negedge sys_clk);
        regAddr = a;
        regRead = 1'b1;
        #1;
        `CHK({winPinStb, winStampStb, winTrigStb}, e)
        @(negedge sys_clk);
        regRead = 1'b0;
        `CHK(regRdValid, vld)
        @(negedge sys_clk);
    endtask : winChk

    task automatic trigEv(input logic [2:0] nt, input logic [2:0] lt, input logic [2:0] fr,
                          input logic [2:0] ez);
        @(negedge sys_clk);
        trigNotify = nt;
        trigLate = lt;
        trigFired = fr;
        trigEnWrZero = ez;
        @(negedge sys_clk);
        trigLate = 3'h0;
        trigFired = 3'h0;
        trigEnWrZero = 3'h0;
    endtask : trigEv

    task automatic statChk(input logic [31:0] e, input logic [1:0] irq);
        regRd(OFS_TRIG_STATUS, rdVal);
        `CHK(rdVal, e)
        `CHK({trigErrIrq, trigDoneIrq}, irq)
    endtask : statChk

    task automatic rstChk;
        `CHK({regRdValid, regRdata, trigErrIrq, trigDoneIrq, rxDecValid, rxDrop}, 37'h0)
        regRd(OFS_DOMAIN_VER, rdVal);
        `CHK(rdVal, DV_RST)
        regRd(OFS_UNIT_INDEX, rdVal);
        `CHK(rdVal, IDX_RST)
        statChk(32'h00000000, 2'h0);
        `CHK({pinSelect, stampSelect, trigSelect}, 4'h0)
    endtask : rstChk

    initial
    begin
        err_total = 0;
        cmp_count = 0;
        srst = 1'b1;
        regAddr = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        regByteEn = 4'h0;
        regWdata = 32'h00000000;
        trigNotify = 3'h0;
        trigLate = 3'h0;
        trigFired = 3'h0;
        trigEnWrZero = 3'h0;
        domainCheckEn = 1'b0;
        rxValid = 1'b0;
        rxVersion = 4'h0;
        rxDomain = 8'h00;
        repeat (5) @(negedge sys_clk);
        srst = 1'b0;
        rstChk();
        $display("test reset values done");
        foreach (regRows[k])
        begin
            regWr(regRows[k].a, regRows[k].be, regRows[k].d);
            regRd(regRows[k].a, rdVal);
            `CHK(rdVal, regRows[k].e)
        end
        $display("test register rows done");
        foreach (rxRows[k])
        begin
            @(negedge sys_clk);
            domainCheckEn = rxRows[k].chk;
            rxVersion = rxRows[k].v;
            rxDomain = rxRows[k].dm;
            rxValid = 1'b1;
            @(negedge sys_clk);
            rxValid = 1'b0;
            `CHK({rxDecValid, rxCapture, rxForwardHost, rxDrop}, {1'b1, rxRows[k].e})
            @(negedge sys_clk);
            `CHK({rxDecValid, rxCapture, rxDrop}, 3'h0)
        end
        $display("test filter rows done");
        winChk(32'h00000000, OFS_WIN_FIRST, 7'b01_01_001, 1'b0);
        winChk(32'h00010101, 16'h05B0, 7'b10_10_010, 1'b0);
        winChk(32'h00000002, 16'h0540, 7'b01_01_100, 1'b0);
        winChk(32'h000E0E00, OFS_WIN_FIRST, 7'b01_01_001, 1'b0);
        winChk(32'h00010100, 16'h05B4, 7'b00_00_000, 1'b1);
        winChk(32'h00000001, 16'h0528, 7'b00_00_000, 1'b1);
        `CHK(regRdata, 32'h00000000)
        $display("test index window done");
        trigEv(3'h0, 3'h2, 3'h2, 3'h0);
        statChk(32'h00000000, 2'h0);
        trigEv(3'h7, 3'h5, 3'h0, 3'h0);
        statChk(32'h00050000, 2'h2);
        regWr(OFS_TRIG_STATUS, 4'hF, 32'h00000000);
        statChk(32'h00050000, 2'h2);
        regWr(OFS_TRIG_STATUS, 4'h4, 32'h00010000);
        statChk(32'h00040000, 2'h2);
        trigEv(3'h7, 3'h0, 3'h0, 3'h4);
        statChk(32'h00000000, 2'h0);
        trigEv(3'h7, 3'h0, 3'h2, 3'h0);
        statChk(32'h00000002, 2'h1);
        regWr(OFS_TRIG_STATUS, 4'h2, 32'h00000002);
        statChk(32'h00000002, 2'h1);
        regWr(OFS_TRIG_STATUS, 4'h1, 32'h00000002);
        statChk(32'h00000000, 2'h0);
        $display("test status flags done");
        regWr(OFS_UNIT_INDEX, 4'hF, 32'h00010102);
        regRd(OFS_UNIT_INDEX, rdVal);
        `CHK(rdVal, 32'h00010102)
        regWr(OFS_DOMAIN_VER, 4'h3, 32'h00000977);
        trigEv(3'h7, 3'h1, 3'h4, 3'h0);
        @(negedge sys_clk);
        srst = 1'b1;
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        rstChk();
        $display("test mid-run reset done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
